// >>> core/dsm_pkg.sv
/*
 * shared types and constants for the data sync marker inserter.
 * assumes one clock domain; all stream inputs come from logic on clk.
 */
package dsm_pkg;

    // =========================================================
    // widths
    localparam int KEY_W = 5;   // right-hand key width
    localparam int CNT_W = 6;   // key count field width
    localparam int SEQ_W = 8;   // wrapping instruction sequence number
    localparam int NUM_W = 8;   // numbered marker value
    localparam int HIST_AW = 5; // key history address width

    // =========================================================
    // constants
    localparam logic [SEQ_W-1:0] HIST_DEPTH = 8'h20;
    localparam logic [NUM_W-1:0] FIRST_MARKER_NUM = 8'h00;
    localparam logic [SEQ_W-1:0] SEQ_ONE = 8'h01;
    localparam logic [NUM_W-1:0] NUM_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    // =========================================================
    // kinds of element on an output stream
    typedef enum logic [1:0] {
        EL_ELEMENT = 2'h0,
        EL_NUMBERED = 2'h1,
        EL_UNNUMBERED = 2'h2,
        EL_RSVD = 2'h3
    } elem_kind_t;

    // control states, gray along idle-scan-mark-emit
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_SCAN = 2'h1,
        S_MARK = 2'h3,
        S_EMIT = 2'h2
    } state_t;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [KEY_W-1:0] key;
    } instr_in_t;

    typedef struct packed {
        logic [SEQ_W-1:0] parent_seq;
        logic [KEY_W-1:0] key;
    } data_in_t;

    typedef struct packed {
        logic valid;
        elem_kind_t kind;
        logic [KEY_W-1:0] key;
        logic [NUM_W-1:0] num;
    } stream_out_t;

endpackage : dsm_pkg

// >>> core/key_history_ram.sv
/*
 * key history memory: right-hand key of each recent instruction element,
 * indexed by the low bits of its sequence number.
 * assumes one clock; read data is registered, valid one cycle after raddr.
 */
`timescale 1ns/1ns
module key_history_ram
    import dsm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port
    input wire logic we,
    input wire logic [HIST_AW-1:0] waddr,
    input wire logic [KEY_W-1:0] wdata,
    // read port
    input wire logic [HIST_AW-1:0] raddr,
    output logic [KEY_W-1:0] rdata
);

    // =========================================================
    // storage
    logic [KEY_W-1:0] mem [0:(1<<HIST_AW)-1];

    // write one key per accepted instruction element
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : key_history_ram

// >>> core/dsm_inserter.sv
/*
 * data sync marker inserter: passes instruction and data trace elements,
 * tracks the last matched instruction element and its key window, and
 * puts numbered or unnumbered markers into both streams.
 * assumes all inputs come from logic on clk, outputs are never stalled,
 * and a data element arrives after its parent instruction element.
 */
`timescale 1ns/1ns
module dsm_inserter
    import dsm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration and control
    input wire logic trace_enable,
    input wire logic [CNT_W-1:0] instr_key_count_field,
    input wire logic data_overflow_recovered,
    input wire logic sync_trace_info,
    input wire logic instr_cancel,
    // instruction element input
    input wire logic instr_in_valid,
    input wire instr_in_t instr_in,
    output logic instr_in_ready,
    // data element input
    input wire logic data_in_valid,
    input wire data_in_t data_in,
    output logic data_in_ready,
    // output streams
    output stream_out_t instr_out,
    output stream_out_t data_out,
    output logic timestamp_req
);

    // =========================================================
    // state
    state_t state_reg;
    state_t state_next;
    logic enable_reg;
    logic lme_valid_reg;
    logic [SEQ_W-1:0] lme_seq_reg;
    logic [KEY_W-1:0] lme_key_reg;
    logic [SEQ_W-1:0] instr_seq_reg;
    logic num_pending_reg;
    logic cancel_pending_reg;
    logic [NUM_W-1:0] marker_num_reg;
    logic [SEQ_W-1:0] q_seq_reg;
    logic [KEY_W-1:0] q_key_reg;
    logic q_later_reg;
    logic mark_numbered_reg;
    logic [SEQ_W-1:0] scan_ptr_reg;
    logic [SEQ_W-1:0] scan_stop_reg;
    logic [KEY_W-1:0] scan_target_reg;
    logic rd_pending_reg;
    logic [KEY_W-1:0] hist_rdata;

    // =========================================================
    // handshakes and window arithmetic
    logic start;
    logic data_take;
    logic instr_take;
    logic [CNT_W-1:0] end_sum;
    logic [CNT_W-1:0] end_key6;
    logic [CNT_W-1:0] start_key6;
    logic [KEY_W-1:0] end_key;
    logic [KEY_W-1:0] start_key;
    logic [SEQ_W-1:0] diff;
    logic q_later;
    logic [SEQ_W-1:0] older;
    logic [SEQ_W-1:0] span;
    logic out_of_reach;
    logic scan_hit;

    assign start = trace_enable & ~enable_reg;
    assign data_take = data_in_valid & data_in_ready & trace_enable;
    assign instr_take = instr_in_valid & instr_in_ready & trace_enable;

    // window edge keys, modulo the key count
    always_comb begin
        end_sum = {1'b0, lme_key_reg} + (instr_key_count_field >> 1);
        if (end_sum >= instr_key_count_field) begin
            end_key6 = end_sum - instr_key_count_field;
        end else begin
            end_key6 = end_sum;
        end
        if (end_key6 + CNT_ONE == instr_key_count_field) begin
            start_key6 = CNT_ZERO;
        end else begin
            start_key6 = end_key6 + CNT_ONE;
        end
    end
    assign end_key = end_key6[KEY_W-1:0];
    assign start_key = start_key6[KEY_W-1:0];

    // position of the new parent against the last match
    assign diff = data_in.parent_seq - lme_seq_reg;
    assign q_later = (diff != '0) & ~diff[SEQ_W-1];
    assign older = q_later ? lme_seq_reg : data_in.parent_seq;
    assign span = instr_seq_reg - older;
    // history too short to prove membership: mark anyway
    assign out_of_reach = (span >= HIST_DEPTH);
    assign scan_hit = rd_pending_reg & (hist_rdata == scan_target_reg);

    // =========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (data_take) begin
                    if (num_pending_reg | cancel_pending_reg | ~lme_valid_reg) begin
                        state_next = S_MARK;
                    end else if (out_of_reach) begin
                        state_next = S_MARK;
                    end else if (diff == '0) begin
                        state_next = S_EMIT;
                    end else begin
                        state_next = S_SCAN;
                    end
                end
            end
            S_SCAN: begin
                if (scan_hit) begin
                    state_next = S_MARK;
                end else if (scan_ptr_reg == scan_stop_reg) begin
                    state_next = S_EMIT;
                end
            end
            S_MARK: begin
                state_next = S_EMIT;
            end
            S_EMIT: begin
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (~trace_enable | start) begin
            state_next = S_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // enable edge detect
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg <= 1'b0;
        end else begin
            enable_reg <= trace_enable;
        end
    end

    // ready flags, registered from the next state
    always_ff @(posedge clk) begin
        if (rst) begin
            data_in_ready <= 1'b0;
            instr_in_ready <= 1'b0;
        end else begin
            data_in_ready <= trace_enable & (state_next == S_IDLE);
            // hold instructions while scanning or marking
            instr_in_ready <= trace_enable & (state_next != S_SCAN) &
                (state_next != S_MARK);
        end
    end

    // =========================================================
    // pending marker causes, set wins over clear; the taking data element
    // consumes them, so a cause that comes while it is in flight waits
    always_ff @(posedge clk) begin
        if (rst) begin
            num_pending_reg <= 1'b0;
            cancel_pending_reg <= 1'b0;
        end else begin
            if (start | data_overflow_recovered | sync_trace_info) begin
                num_pending_reg <= 1'b1;
            end else if (data_take) begin
                num_pending_reg <= 1'b0;
            end
            if (instr_cancel) begin
                cancel_pending_reg <= 1'b1;
            end else if (start | data_take) begin
                cancel_pending_reg <= 1'b0;
            end
        end
    end

    // latch the accepted data element
    always_ff @(posedge clk) begin
        if (rst) begin
            q_seq_reg <= '0;
            q_key_reg <= '0;
            q_later_reg <= 1'b0;
            mark_numbered_reg <= 1'b0;
        end else if (data_take && state_reg == S_IDLE) begin
            q_seq_reg <= data_in.parent_seq;
            q_key_reg <= data_in.key;
            q_later_reg <= q_later;
            mark_numbered_reg <= num_pending_reg;
        end
    end

    // =========================================================
    // scan walks the history between last match and parent
    always_ff @(posedge clk) begin
        if (rst) begin
            scan_ptr_reg <= '0;
            scan_stop_reg <= '0;
            scan_target_reg <= '0;
            rd_pending_reg <= 1'b0;
        end else if (state_reg == S_IDLE) begin
            rd_pending_reg <= 1'b0;
            if (q_later) begin
                scan_ptr_reg <= lme_seq_reg + SEQ_ONE;
                scan_stop_reg <= data_in.parent_seq;
                scan_target_reg <= end_key;
            end else begin
                scan_ptr_reg <= data_in.parent_seq + SEQ_ONE;
                // the last match is read too: with two keys it carries the backward edge key
                scan_stop_reg <= lme_seq_reg + SEQ_ONE;
                scan_target_reg <= start_key;
            end
        end else if (state_reg == S_SCAN) begin
            rd_pending_reg <= (scan_ptr_reg != scan_stop_reg);
            if (scan_ptr_reg != scan_stop_reg) begin
                scan_ptr_reg <= scan_ptr_reg + SEQ_ONE;
            end
        end else begin
            rd_pending_reg <= 1'b0;
        end
    end

    // history of instruction keys
    key_history_ram u_hist (
        .clk(clk),
        .rst(rst),
        .we(instr_take),
        .waddr(instr_seq_reg[HIST_AW-1:0]),
        .wdata(instr_in.key),
        .raddr(scan_ptr_reg[HIST_AW-1:0]),
        .rdata(hist_rdata)
    );

    // =========================================================
    // instruction sequence counter, restarts at enable
    always_ff @(posedge clk) begin
        if (rst) begin
            instr_seq_reg <= '0;
        end else if (start) begin
            instr_seq_reg <= '0;
        end else if (instr_take) begin
            instr_seq_reg <= instr_seq_reg + SEQ_ONE;
        end
    end

    // last matched element
    always_ff @(posedge clk) begin
        if (rst) begin
            lme_valid_reg <= 1'b0;
            lme_seq_reg <= '0;
            lme_key_reg <= '0;
        end else if (start | data_overflow_recovered) begin
            lme_valid_reg <= 1'b0;
        end else if (state_reg == S_EMIT && (~lme_valid_reg | q_later_reg)) begin
            lme_valid_reg <= 1'b1;
            lme_seq_reg <= q_seq_reg;
            lme_key_reg <= q_key_reg;
        end
    end

    // numbered marker value
    always_ff @(posedge clk) begin
        if (rst) begin
            marker_num_reg <= FIRST_MARKER_NUM;
        end else if (start) begin
            marker_num_reg <= FIRST_MARKER_NUM;
        end else if (state_reg == S_MARK && mark_numbered_reg) begin
            marker_num_reg <= marker_num_reg + NUM_ONE;
        end
    end

    // =========================================================
    // data stream output
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= '0;
        end else begin
            data_out <= '0;
            if (state_reg == S_MARK) begin
                data_out.valid <= 1'b1;
                data_out.kind <= mark_numbered_reg ? EL_NUMBERED : EL_UNNUMBERED;
                data_out.num <= mark_numbered_reg ? marker_num_reg : '0;
            end else if (state_reg == S_EMIT) begin
                data_out.valid <= 1'b1;
                data_out.kind <= EL_ELEMENT;
                data_out.key <= q_key_reg;
            end
        end
    end

    // instruction stream output, marker in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            instr_out <= '0;
        end else begin
            instr_out <= '0;
            if (state_reg == S_MARK) begin
                instr_out.valid <= 1'b1;
                instr_out.kind <= mark_numbered_reg ? EL_NUMBERED : EL_UNNUMBERED;
                instr_out.num <= mark_numbered_reg ? marker_num_reg : '0;
            end else if (instr_take) begin
                instr_out.valid <= 1'b1;
                instr_out.kind <= EL_ELEMENT;
                instr_out.key <= instr_in.key;
            end
        end
    end

    // timestamp request with every numbered marker
    always_ff @(posedge clk) begin
        if (rst) begin
            timestamp_req <= 1'b0;
        end else begin
            timestamp_req <= (state_reg == S_MARK) & mark_numbered_reg;
        end
    end

    // every marker is mirrored on both streams in one cycle
    // a timestamp request goes with each numbered value, in the same cycle

endmodule : dsm_inserter

// >>> test/dsm_inserter_props.sv
/* checker on the inserter ports: marker pairing, numbers, stamps, answers.
   assumes a bind to dsm_inserter, one clock, synchronous reset. */
`timescale 1ns/1ns
module dsm_inserter_props
    import dsm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic trace_enable,
    input wire logic data_overflow_recovered,
    input wire logic sync_trace_info,
    input wire logic instr_cancel,
    // handshakes
    input wire logic instr_in_valid,
    input wire instr_in_t instr_in,
    input wire logic instr_in_ready,
    input wire logic data_in_valid,
    input wire logic data_in_ready,
    // outputs
    input wire stream_out_t instr_out,
    input wire stream_out_t data_out,
    input wire logic timestamp_req
);
    // ==========
    // helper state
    logic en_reg, pn_reg, pa_reg, nn_reg, na_reg, has_reg;
    logic [NUM_W-1:0] last_reg;
    wire d_take = data_in_valid && data_in_ready && trace_enable;
    wire i_take = instr_in_valid && instr_in_ready && trace_enable;
    wire d_mark = data_out.valid && data_out.kind != EL_ELEMENT;
    wire d_num = data_out.valid && data_out.kind == EL_NUMBERED;
    wire rise = trace_enable && !en_reg;
    wire p_num = rise || data_overflow_recovered || sync_trace_info;
    // requests waiting for the next data take
    always_ff @(posedge clk) begin
        if (rst) begin
            en_reg <= 1'b0;
            pn_reg <= 1'b0;
            pa_reg <= 1'b0;
        end else begin
            en_reg <= trace_enable;
            pn_reg <= d_take ? p_num : (pn_reg || p_num);
            pa_reg <= d_take ? instr_cancel : (pa_reg || instr_cancel);
        end
    end
    // what the taken element is owed, up to its first output
    always_ff @(posedge clk) begin
        if (rst) begin
            nn_reg <= 1'b0;
            na_reg <= 1'b0;
        end else if (d_take) begin
            nn_reg <= pn_reg;
            na_reg <= pn_reg || pa_reg;
        end else if (data_out.valid) begin
            nn_reg <= 1'b0;
            na_reg <= 1'b0;
        end
    end
    // last numbered value since enable
    always_ff @(posedge clk) begin
        if (rst || rise) begin
            has_reg <= 1'b0;
        end else if (d_num) begin
            has_reg <= 1'b1;
            last_reg <= data_out.num;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_elem;
        data_out.valid && data_out.kind == EL_ELEMENT;
    endsequence
    sequence s_imark;
        instr_out.valid && instr_out.kind != EL_ELEMENT;
    endsequence
    AST_PAIR_KIND: assert property (
        d_mark |-> instr_out.valid && instr_out.kind == data_out.kind
            && (!d_num || instr_out.num == data_out.num))
        else $error("instruction marker differs");
    AST_MIRROR: assert property (s_imark |-> d_mark)
        else $error("lone instruction marker");
    AST_MARK_ELEM: assert property (d_mark |=> s_elem)
        else $error("marker not followed by element");
    AST_STAMP: assert property (timestamp_req == d_num)
        else $error("timestamp request out of step");
    AST_NUM_STEP: assert property (
        d_num |-> data_out.num == (has_reg ? last_reg + NUM_ONE : FIRST_MARKER_NUM))
        else $error("marker number out of sequence");
    AST_NEED_NUM: assert property (nn_reg && data_out.valid |-> d_num)
        else $error("numbered marker missing");
    AST_NEED_ANY: assert property (na_reg && data_out.valid |-> d_mark)
        else $error("marker missing after cancel");
    AST_DATA_ANSWER: assert property (d_take |-> ##[2:80] s_elem)
        else $error("data element lost");
    AST_DATA_HOLD: assert property (d_take |=> !data_in_ready ##1
        (!data_in_ready || data_out.valid && data_out.kind == EL_ELEMENT))
        else $error("data ready back too soon");
    AST_INSTR_ANSWER: assert property (
        i_take |=> instr_out.valid && instr_out.kind == EL_ELEMENT
            && instr_out.key == $past(instr_in.key))
        else $error("instruction element lost");
endmodule : dsm_inserter_props

bind dsm_inserter dsm_inserter_props props (.clk(clk), .rst(rst), .trace_enable(trace_enable),
    .data_overflow_recovered(data_overflow_recovered), .sync_trace_info(sync_trace_info),
    .instr_cancel(instr_cancel), .instr_in_valid(instr_in_valid), .instr_in(instr_in),
    .instr_in_ready(instr_in_ready), .data_in_valid(data_in_valid),
    .data_in_ready(data_in_ready), .instr_out(instr_out), .data_out(data_out),
    .timestamp_req(timestamp_req));

// >>> test/analyzer_model.sv
/* far side analyzer: finds the parent of each data element by key searches.
   assumes outputs never stall and carry no overflow or discard elements. */
`timescale 1ns/1ns
module analyzer_model
    import dsm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic trace_enable,
    input wire logic [CNT_W-1:0] key_count,
    // streams
    input wire stream_out_t instr_out,
    input wire stream_out_t data_out,
    // parent position found, -1 if none
    output int match_pos
);
    // ==========
    // analyzer state
    int keys [$];
    int mark_pos, lme, lme_key;
    logic after_mark, en_q;
    // latest earlier element with the key
    function automatic int back(input int start, input int key);
        for (int p = start; p >= 0; p--) begin
            if (keys[p] == key) begin
                return p;
            end
        end
        return -1;
    endfunction : back
    // next element with the key, stopping at the end key
    function automatic int fwd(input int start, input int key, input int end_key);
        for (int p = start; p < keys.size(); p++) begin
            if (keys[p] == key) begin
                return p;
            end else if (keys[p] == end_key) begin
                return -1;
            end
        end
        return -1;
    endfunction : fwd
    // match one data element
    task automatic resolve(input int key);
        int p;
        if (after_mark || lme < 0) begin
            p = back(mark_pos - 1, key);
            if (p >= 0 && (lme < 0 || p > lme)) begin
                lme = p;
                lme_key = key;
            end
        end else begin
            p = fwd(lme, key, (lme_key + int'(key_count) / 2) % int'(key_count));
            if (p >= 0) begin
                lme = p;
                lme_key = key;
            end else begin
                p = back(lme - 1, key);
            end
        end
        after_mark = 1'b0;
        match_pos = p;
    endtask : resolve
    // follow both streams
    always @(posedge clk) begin
        if (rst || (trace_enable && !en_q)) begin
            keys.delete();
            lme = -1;
            after_mark = 1'b0;
            match_pos = -1;
        end else begin
            if (instr_out.valid && instr_out.kind == EL_ELEMENT) begin
                keys.push_back(int'(instr_out.key));
            end else if (instr_out.valid) begin
                mark_pos = keys.size();
            end
            if (data_out.valid && data_out.kind != EL_ELEMENT) begin
                after_mark = 1'b1;
            end else if (data_out.valid) begin
                resolve(int'(data_out.key));
            end
        end
        en_q = trace_enable;
    end
endmodule : analyzer_model

// >>> test/tb_top.sv
/* bench for the marker inserter: window cases, request pulses, random runs.
   assumes package, design, checker and analyzer model compiled before it. */
`timescale 1ns/1ns
module tb_top
    import dsm_pkg::*;
;
    // ==========
    // signals
    logic clk, rst, trace_enable, ovf, sync, cancel, iv, dv, iready, dready, ts;
    logic [CNT_W-1:0] kcount;
    instr_in_t ii;
    data_in_t di;
    stream_out_t io, dout;
    int match_pos, err_total, checks, mnum, off, seed;
    int hist [$];
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    dsm_inserter dut (.clk(clk), .rst(rst), .trace_enable(trace_enable),
        .instr_key_count_field(kcount), .data_overflow_recovered(ovf),
        .sync_trace_info(sync), .instr_cancel(cancel), .instr_in_valid(iv), .instr_in(ii),
        .instr_in_ready(iready), .data_in_valid(dv), .data_in(di), .data_in_ready(dready),
        .instr_out(io), .data_out(dout), .timestamp_req(ts));
    analyzer_model far_end (.clk(clk), .rst(rst), .trace_enable(trace_enable),
        .key_count(kcount), .instr_out(io), .data_out(dout), .match_pos(match_pos));
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic stall();
        err_total++;
        $display("Error %0t: wait ran out", $time);
        summarize();
    endtask : stall
    // one instruction element, held until taken
    task automatic send_instr(input logic [KEY_W-1:0] key);
        int n;
        @(posedge clk);
        iv <= 1'b1;
        ii <= key;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) stall();
        end while (iready !== 1'b1);
        iv <= 1'b0;
        hist.push_back(int'(key));
        @(negedge clk);
        check({io.valid, io.kind, io.key}, {1'b1, EL_ELEMENT, key}, "instr out");
    endtask : send_instr
    // one data element; want EL_RSVD leaves the marker choice open
    task automatic send_data(input int par, input elem_kind_t want);
        int n;
        logic [KEY_W-1:0] key;
        key = KEY_W'(hist[par]);
        @(posedge clk);
        dv <= 1'b1;
        di <= {SEQ_W'(par), key};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) stall();
        end while (dready !== 1'b1);
        dv <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n > 80) stall();
        end while (dout.valid !== 1'b1);
        if (want != EL_RSVD) check(dout.kind, want, "marker kind");
        if (dout.kind == EL_NUMBERED) begin
            check({ts, dout.num}, {1'b1, NUM_W'(mnum)}, "numbered");
            mnum++;
        end
        if (dout.kind != EL_ELEMENT) @(negedge clk);
        check({dout.valid, dout.kind, dout.key}, {1'b1, EL_ELEMENT, key}, "data");
        @(negedge clk);
        check(match_pos, par, "parent link");
    endtask : send_data
    // ==========
    // main sequence
    initial begin
        {rst, trace_enable, ovf, sync, cancel, iv, dv} = 7'h40;
        ii = '0;
        di = '0;
        kcount = 6'h06;
        err_total = 0;
        checks = 0;
        mnum = int'(FIRST_MARKER_NUM);
        seed = $urandom(35894);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        trace_enable <= 1'b1;
        for (int k = 0; k < 6; k++) send_instr(KEY_W'(k));
        send_data(1, EL_NUMBERED);
        send_data(2, EL_ELEMENT);
        send_data(4, EL_ELEMENT);
        // second round of keys: parent 11 lies past the forward edge
        for (int k = 0; k < 6; k++) send_instr(KEY_W'(k));
        send_data(11, EL_UNNUMBERED);
        send_data(9, EL_ELEMENT);
        send_data(8, EL_UNNUMBERED);
        send_instr(5'h00);
        send_data(12, EL_ELEMENT);
        $display("window test done, mismatches %0d", err_total);
        for (int k = 0; k < 3; k++) begin
            send_instr(KEY_W'(hist.size() % 6));
            @(posedge clk);
            {sync, ovf, cancel} <= 3'h4 >> k;
            @(posedge clk);
            {sync, ovf, cancel} <= 3'h0;
            send_data(hist.size() - 1, k == 2 ? EL_UNNUMBERED : EL_NUMBERED);
        end
        $display("pulse test done, mismatches %0d", err_total);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            trace_enable <= 1'b0;
            kcount <= CNT_W'($urandom_range(32, 2));
            repeat (2) @(posedge clk);
            trace_enable <= 1'b1;
            hist.delete();
            mnum = int'(FIRST_MARKER_NUM);
            for (int d = 0; d < 20; d++) begin
                repeat ($urandom_range(4, 1)) send_instr(KEY_W'(hist.size() % kcount));
                off = $urandom_range(3, 0) % kcount;
                if (off >= hist.size()) off = 0;
                send_data(hist.size() - 1 - off, d == 0 ? EL_NUMBERED : EL_RSVD);
            end
            $display("random session %0d done, mismatches %0d", s, err_total);
        end
        summarize();
    end
endmodule : tb_top
